/* spvp_consts.svh */
// spvp_consts.svh - named figures of the serial program/verify port
// assumes: included by the package only; definitions only
`ifndef SPVP_CONSTS_SVH
`define SPVP_CONSTS_SVH

// ----------------------------------------------------------------
// command field
// ----------------------------------------------------------------
`define SPVP_CMD_LDCFG 6'h00
`define SPVP_CMD_LDDATA 6'h02
`define SPVP_CMD_RDDATA 6'h04
`define SPVP_CMD_INCADDR 6'h06
`define SPVP_CMD_BEGPROG 6'h08
`define SPVP_CMD_ENDPROG 6'h0e

// ----------------------------------------------------------------
// frame positions, counted from 0 (start bit) or rising edge 1
// ----------------------------------------------------------------
`define SPVP_CMD_LAST 5'd5
`define SPVP_DAT_FIRST 5'd1
`define SPVP_DAT_LAST 5'd14
`define SPVP_FRM_STOP 5'd15
`define SPVP_RD_ON 5'd2
`define SPVP_RD_LAST 5'd15
`define SPVP_RD_OFF 5'd16

// ----------------------------------------------------------------
// memory map
// ----------------------------------------------------------------
`define SPVP_CFG_BASE 14'h2000
`define SPVP_CFG_HI 6'h20
`define SPVP_USER_WORDS 2048
`define SPVP_CFG_WORDS 256
`define SPVP_ERASED 14'h3fff
`define SPVP_CFG_WORD_OFS 8'h07

// ----------------------------------------------------------------
// timing and algorithm
// ----------------------------------------------------------------
`define SPVP_CLK_MHZ 100
`define SPVP_GAP_NS 1000
`define SPVP_GAP_CYC ((`SPVP_GAP_NS * `SPVP_CLK_MHZ + 999) / 1000)
`define SPVP_PROG_US 100
`define SPVP_PROG_CYC (`SPVP_PROG_US * `SPVP_CLK_MHZ)
`define SPVP_HALF_CYC 5'd10
`define SPVP_LOW_CYC 5'd2
`define SPVP_MAX_TRIES 7'd25
`define SPVP_EXTRA_MULT 7'd3
`define SPVP_CFG_CYCLES 7'd100
`define SPVP_HOST_WORDS 256

`endif

/* spvp_pkg.sv */
// spvp_pkg.sv - types shared by both ends of the port
// assumes: spvp_consts.svh is on the include path
package spvp_pkg;
`include "spvp_consts.svh"

	typedef logic [13:0] spvp_word_t;
	typedef logic [13:0] spvp_addr_t;

	typedef enum logic [5:0] {
		CMD_LDCFG = `SPVP_CMD_LDCFG,
		CMD_LDDATA = `SPVP_CMD_LDDATA,
		CMD_RDDATA = `SPVP_CMD_RDDATA,
		CMD_INCADDR = `SPVP_CMD_INCADDR,
		CMD_BEGPROG = `SPVP_CMD_BEGPROG,
		CMD_ENDPROG = `SPVP_CMD_ENDPROG
	} spvp_cmd_t;

	typedef enum logic [1:0] {
		D_OFF = 2'b00, D_CMD = 2'b01, D_DATA = 2'b10
	} spvp_dst_t;

	typedef enum logic [2:0] {
		E_IDLE = 3'b000, E_CMD = 3'b001, E_GAP1 = 3'b010,
		E_DATA = 3'b011, E_GAP2 = 3'b100
	} spvp_est_t;

	typedef enum logic [3:0] {
		H_IDLE = 4'b0000, H_EXIT = 4'b0001, H_ENTER = 4'b0010,
		H_POP = 4'b0011, H_PLD = 4'b0100, H_PBG = 4'b0101,
		H_PWT = 4'b0110, H_PEN = 4'b0111, H_RD = 4'b1000,
		H_CHK = 4'b1001, H_INC = 4'b1010, H_VRD = 4'b1011,
		H_VINC = 4'b1100, H_CLC = 4'b1101, H_CINC = 4'b1110,
		H_DONE = 4'b1111
	} spvp_hst_t;

	typedef enum logic [1:0] {
		PH_PROG = 2'b00, PH_VMIN = 2'b01, PH_VMAX = 2'b10, PH_CFG = 2'b11
	} spvp_phase_t;
endpackage

/* spvp_if.sv */
// spvp_if.sv - the three pins between programmer and device
// assumes: the bench instantiates it and hands one modport to each end
`timescale 1ns/10ps
interface spvp_if;
	logic serial_clock_pin;
	logic master_clear_pin;
	logic host_data_o;
	logic host_data_oe;
	logic dev_data_o;
	logic dev_data_oe;
	logic serial_data_pin;

	// an undriven data line reads low, as for mode entry
	assign serial_data_pin = host_data_oe ? host_data_o :
		(dev_data_oe ? dev_data_o : 1'b0);

	modport dev (
		input serial_clock_pin, master_clear_pin, serial_data_pin,
		output dev_data_o, dev_data_oe
	);
	modport host (
		output serial_clock_pin, master_clear_pin, host_data_o,
		output host_data_oe,
		input serial_data_pin
	);
endinterface

/* spvp_fifo.sv */
// spvp_fifo.sv - word buffer in front of the programmer engine
// assumes: one clock; both sides use valid/ready
`timescale 1ns/10ps
module spvp_fifo #(
	parameter int W = 14,
	parameter int D = 16
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW:0] wp_r, rp_r;
	wire push_w = in_valid & in_ready;
	wire pop_w = out_valid & out_ready;
	wire [AW:0] fill_w = wp_r - rp_r;

	assign in_ready = fill_w != (AW+1)'(D);
	assign out_valid = fill_w != '0;
	assign out_data = mem[rp_r[AW-1:0]];

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wp_r <= '0;
			rp_r <= '0;
		end else begin
			wp_r <= wp_r + (AW+1)'(push_w);
			rp_r <= rp_r + (AW+1)'(pop_w);
		end
	end

	always_ff @(posedge clk) begin
		if (push_w)
			mem[wp_r[AW-1:0]] <= in_data;
	end
endmodule // spvp_fifo

/* spvp_dev.sv */
// spvp_dev.sv - device end of the serial program/verify port
// assumes: spvp_if carries the pins; clk 100 MHz; link clock from host
`timescale 1ns/10ps
// Summary of operation
// - clock, data low, master clear high: enter
// - after entry, address user program memory
// - six command bits, falling edge, lsb first
// - programmer waits 1 us before data
// - data frame: start, 14 bits, stop
// - read lsb on rising two, load falling two
// - programmer leaves 1 us between commands
// - drive on rising, sample on falling
// - load configuration sets pc to 0x2000
// - configuration space kept until mode exit
// - load data holds word for programming
// - read drives pin rising two to sixteen
// - increment address advances pc by one
// - begin programming starts after a load
// - programmer uses 100 us pulses
// - end programming stops the write
// - programmer retries, fails past 25, adds 3N
// - programmer verifies at min and max supply
// - configuration word gets 100 program cycles
// - core clock stopped while port active
// - pc top bit sticks, wraps to 0x2000
module spvp_dev
	import spvp_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	spvp_if.dev link,
	output logic mode_active,
	output logic core_clk_stop,
	output logic prog_active,
	output spvp_addr_t addr,
	output logic [5:0] last_cmd
);
	// ----------------------------------------------------------------
	// pin synchronisers: a change counts once stages two and three agree
	// ----------------------------------------------------------------
	logic [2:0] s1_r, s2_r, s3_r, lvl_r;
	wire [2:0] pin_w = {link.master_clear_pin, link.serial_data_pin,
		link.serial_clock_pin};
	wire [2:0] lvl_nxt = (s2_r & s3_r) | (lvl_r & (s2_r ^ s3_r));
	wire rise_w = lvl_nxt[0] & ~lvl_r[0];
	wire fall_w = ~lvl_nxt[0] & lvl_r[0];
	wire din_w = lvl_nxt[1];
	wire master_clear_pin_w = lvl_nxt[2];
	// clock and data must both sit low as master clear rises
	wire enter_w = master_clear_pin_w & ~lvl_r[2] & ~lvl_nxt[0] & ~lvl_nxt[1];

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			lvl_r <= '0;
		end else begin
			s1_r <= pin_w;
			s2_r <= s1_r;
			s3_r <= s2_r;
			lvl_r <= lvl_nxt;
		end
	end

	// ----------------------------------------------------------------
	// memories: user space and configuration space
	// ----------------------------------------------------------------
	spvp_word_t user_mem [`SPVP_USER_WORDS];
	spvp_word_t cfg_mem [`SPVP_CFG_WORDS];

	spvp_dst_t st_r, st_nxt;
	spvp_addr_t pc_r, pc_nxt;
	logic [5:0] cmd_r, cmd_nxt, last_r, last_nxt;
	logic [4:0] fcnt_r, fcnt_nxt, rcnt_r, rcnt_nxt;
	spvp_word_t rx_r, rx_nxt, tx_r, tx_nxt, load_r, load_nxt;
	logic oe_r, oe_nxt, do_r, do_nxt;
	logic prog_r, prog_nxt, rd_r, rd_nxt;
	logic wr_en;

	// unimplemented user space aliases onto the physical words
	wire in_cfg_w = pc_r[13];
	wire spvp_word_t rd_word_w = in_cfg_w ? cfg_mem[pc_r[7:0]] :
		user_mem[pc_r[10:0]];

	// configuration space keeps bit 13 and wraps in its low byte
	function automatic spvp_addr_t pc_inc(input spvp_addr_t pc);
		if (pc[13])
			pc_inc = {`SPVP_CFG_HI, 8'(pc[7:0] + 8'h01)};
		else
			pc_inc = {1'b0, 13'(pc[12:0] + 13'h0001)};
	endfunction

	// ----------------------------------------------------------------
	// command and data decode
	// ----------------------------------------------------------------
	wire [5:0] cmd_sh_w = {din_w, cmd_r[5:1]};
	wire cmd_done_w = fall_w & (fcnt_r == `SPVP_CMD_LAST);
	wire is_ldcfg_w = cmd_sh_w == CMD_LDCFG;
	wire is_lddata_w = cmd_sh_w == CMD_LDDATA;
	wire is_rd_w = cmd_sh_w == CMD_RDDATA;
	wire is_inc_w = cmd_sh_w == CMD_INCADDR;
	wire is_beg_w = cmd_sh_w == CMD_BEGPROG;
	wire is_end_w = cmd_sh_w == CMD_ENDPROG;
	wire [4:0] rcnt_inc_w = rcnt_r + 5'd1;
	wire dat_bit_w = (fcnt_r >= `SPVP_DAT_FIRST) &
		(fcnt_r <= `SPVP_DAT_LAST);
	wire tx_bit_w = (rcnt_inc_w >= `SPVP_RD_ON) &
		(rcnt_inc_w <= `SPVP_RD_LAST);

	always_comb begin
		st_nxt = st_r;
		pc_nxt = pc_r;
		cmd_nxt = cmd_r;
		last_nxt = last_r;
		fcnt_nxt = fcnt_r;
		rcnt_nxt = rcnt_r;
		rx_nxt = rx_r;
		tx_nxt = tx_r;
		load_nxt = load_r;
		oe_nxt = oe_r;
		do_nxt = do_r;
		prog_nxt = prog_r;
		rd_nxt = rd_r;
		wr_en = 1'b0;
		unique case (st_r)
			D_OFF: begin
				if (enter_w) begin
					st_nxt = D_CMD;
					pc_nxt = '0;
					cmd_nxt = '0;
					fcnt_nxt = '0;
					rcnt_nxt = '0;
					load_nxt = `SPVP_ERASED;
				end
			end
			D_CMD: begin
				if (fall_w) begin
					cmd_nxt = cmd_sh_w;
					fcnt_nxt = fcnt_r + 5'd1;
				end
				if (cmd_done_w) begin
					fcnt_nxt = '0;
					last_nxt = cmd_sh_w;
					rcnt_nxt = '0;
					if (is_ldcfg_w) begin
						pc_nxt = `SPVP_CFG_BASE;
						st_nxt = D_DATA;
						rd_nxt = 1'b0;
					end
					if (is_lddata_w) begin
						st_nxt = D_DATA;
						rd_nxt = 1'b0;
					end
					if (is_rd_w) begin
						st_nxt = D_DATA;
						rd_nxt = 1'b1;
						tx_nxt = rd_word_w;
					end
					if (is_inc_w)
						pc_nxt = pc_inc(pc_r);
					if (is_beg_w)
						prog_nxt = 1'b1;
					if (is_end_w) begin
						wr_en = prog_r;
						prog_nxt = 1'b0;
					end
				end
			end
			D_DATA: begin
				if (rise_w) begin
					rcnt_nxt = rcnt_inc_w;
					if (rd_r && rcnt_inc_w == `SPVP_RD_ON)
						oe_nxt = 1'b1;
					if (rd_r && tx_bit_w) begin
						do_nxt = tx_r[0];
						tx_nxt = tx_r >> 1;
					end
					if (rd_r && rcnt_inc_w == `SPVP_RD_OFF) begin
						oe_nxt = 1'b0;
						do_nxt = 1'b0;
					end
				end
				if (fall_w) begin
					fcnt_nxt = fcnt_r + 5'd1;
					if (!rd_r && dat_bit_w)
						rx_nxt = {din_w, rx_r[13:1]};
					if (fcnt_r == `SPVP_FRM_STOP) begin
						st_nxt = D_CMD;
						fcnt_nxt = '0;
						rcnt_nxt = '0;
						oe_nxt = 1'b0;
						if (!rd_r)
							load_nxt = rx_r;
					end
				end
			end
			default: st_nxt = D_OFF;
		endcase
		// master clear low drops the mode from any state
		if (!master_clear_pin_w) begin
			st_nxt = D_OFF;
			oe_nxt = 1'b0;
			do_nxt = 1'b0;
			prog_nxt = 1'b0;
			wr_en = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_r <= D_OFF;
			pc_r <= '0;
			cmd_r <= '0;
			last_r <= '0;
			fcnt_r <= '0;
			rcnt_r <= '0;
			rx_r <= '0;
			tx_r <= '0;
			load_r <= `SPVP_ERASED;
			oe_r <= 1'b0;
			do_r <= 1'b0;
			prog_r <= 1'b0;
			rd_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			pc_r <= pc_nxt;
			cmd_r <= cmd_nxt;
			last_r <= last_nxt;
			fcnt_r <= fcnt_nxt;
			rcnt_r <= rcnt_nxt;
			rx_r <= rx_nxt;
			tx_r <= tx_nxt;
			load_r <= load_nxt;
			oe_r <= oe_nxt;
			do_r <= do_nxt;
			prog_r <= prog_nxt;
			rd_r <= rd_nxt;
		end
	end

	// word lands when the pulse ends, so a cut pulse writes nothing
	always_ff @(posedge clk) begin
		if (wr_en && in_cfg_w)
			cfg_mem[pc_r[7:0]] <= load_r;
		if (wr_en && !in_cfg_w)
			user_mem[pc_r[10:0]] <= load_r;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	wire active_w = st_r != D_OFF;
	assign mode_active = active_w;
	assign core_clk_stop = active_w;
	assign prog_active = prog_r;
	assign addr = pc_r;
	assign last_cmd = last_r;
	assign link.dev_data_o = do_r;
	assign link.dev_data_oe = oe_r;
endmodule // spvp_dev

/* spvp_host.sv */
// spvp_host.sv - programmer end: pin engine plus programming algorithm
// assumes: spvp_if carries the pins; words arrive through spvp_fifo
`timescale 1ns/10ps
module spvp_host
	import spvp_pkg::*;
#(
	parameter int PROG_CYC = `SPVP_PROG_CYC
) (
	input wire logic clk,
	input wire logic resetn,
	spvp_if.host link,
	input wire logic start,
	input wire logic [7:0] n_words,
	input wire spvp_word_t cfg_word,
	input wire logic in_valid,
	output logic in_ready,
	input wire spvp_word_t in_data,
	output logic busy,
	output logic done,
	output logic prog_fail,
	output logic vmin_err,
	output logic vmax_err,
	output logic cfg_err,
	output logic verify_high_voltage,
	output spvp_phase_t supply_sel
);
	// ----------------------------------------------------------------
	// data pin synchroniser
	// ----------------------------------------------------------------
	logic s1_r, s2_r, s3_r, lvl_r;
	wire din_w = (s2_r & s3_r) | (lvl_r & (s2_r ^ s3_r));
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			{s1_r, s2_r, s3_r, lvl_r} <= '0;
		end else begin
			{s1_r, s2_r, s3_r, lvl_r} <= {link.serial_data_pin, s1_r, s2_r,
				din_w};
		end
	end

	// ----------------------------------------------------------------
	// pin engine: command, gap, data frame, gap
	// ----------------------------------------------------------------
	spvp_hst_t st_r, st_nxt;
	spvp_est_t est_r, est_nxt;
	logic [6:0] ecnt_r, ecnt_nxt;
	logic [4:0] bit_r, bit_nxt;
	logic [15:0] sh_r, sh_nxt;
	spvp_word_t rx_r, rx_nxt, eword_r, eword_nxt, cur_r, cur_nxt;
	logic sclk_r, sclk_nxt, hoe_r, hoe_nxt, hdo_r, hdo_nxt;
	logic ehas_r, ehas_nxt, erd_r, erd_nxt;

	wire issue_w = st_r inside {H_PLD, H_PBG, H_PEN, H_RD, H_VRD, H_INC,
		H_VINC, H_CLC, H_CINC};
	wire go_w = issue_w & (est_r == E_IDLE);
	wire spvp_cmd_t cmd_w = (st_r == H_PLD) ? CMD_LDDATA :
		(st_r == H_PBG) ? CMD_BEGPROG : (st_r == H_PEN) ? CMD_ENDPROG :
		(st_r inside {H_RD, H_VRD}) ? CMD_RDDATA :
		(st_r == H_CLC) ? CMD_LDCFG : CMD_INCADDR;
	wire gap_end_w = ecnt_r == 7'(`SPVP_GAP_CYC - 1);
	wire e_done_w = (est_r == E_GAP2) & gap_end_w;
	wire clk_phase_w = est_r inside {E_CMD, E_DATA};
	wire [4:0] last_bit_w = (est_r == E_CMD) ? `SPVP_CMD_LAST :
		`SPVP_FRM_STOP;

	always_comb begin
		est_nxt = est_r;
		ecnt_nxt = ecnt_r;
		bit_nxt = bit_r;
		sh_nxt = sh_r;
		rx_nxt = rx_r;
		eword_nxt = eword_r;
		sclk_nxt = sclk_r;
		hoe_nxt = hoe_r;
		hdo_nxt = hdo_r;
		ehas_nxt = ehas_r;
		erd_nxt = erd_r;
		if (go_w) begin
			est_nxt = E_CMD;
			ecnt_nxt = '0;
			bit_nxt = '0;
			sh_nxt = {10'h000, cmd_w};
			ehas_nxt = st_r inside {H_PLD, H_RD, H_VRD, H_CLC};
			erd_nxt = st_r inside {H_RD, H_VRD};
			eword_nxt = (st_r == H_CLC) ? `SPVP_ERASED : cur_r;
		end
		if (clk_phase_w) begin
			ecnt_nxt = 7'(ecnt_r + 7'd1);
			if (ecnt_r == '0) begin
				sclk_nxt = 1'b1;
				if (est_r == E_CMD || !erd_r) begin
					hoe_nxt = 1'b1;
					hdo_nxt = sh_r[0];
					sh_nxt = sh_r >> 1;
				end
			end
			if (ecnt_r == {2'b00, `SPVP_HALF_CYC}) begin
				sclk_nxt = 1'b0;
				if (est_r == E_DATA && erd_r && bit_r >= `SPVP_DAT_FIRST &&
						bit_r <= `SPVP_DAT_LAST)
					rx_nxt = {din_w, rx_r[13:1]};
			end
			// short low phase: only read sampling needs the long high
			if (ecnt_r == {2'b00, `SPVP_HALF_CYC} +
					{2'b00, `SPVP_LOW_CYC} - 7'd1) begin
				ecnt_nxt = '0;
				bit_nxt = bit_r + 5'd1;
				if (bit_r == last_bit_w) begin
					bit_nxt = '0;
					hoe_nxt = 1'b0;
					hdo_nxt = 1'b0;
					est_nxt = (est_r == E_CMD && ehas_r) ? E_GAP1 : E_GAP2;
				end
			end
		end
		if (est_r inside {E_GAP1, E_GAP2}) begin
			ecnt_nxt = 7'(ecnt_r + 7'd1);
			if (gap_end_w) begin
				ecnt_nxt = '0;
				est_nxt = (est_r == E_GAP1) ? E_DATA : E_IDLE;
				sh_nxt = {1'b0, eword_r, 1'b0};
			end
		end
	end

	// ----------------------------------------------------------------
	// programming algorithm
	// ----------------------------------------------------------------
	spvp_word_t words [`SPVP_HOST_WORDS];
	spvp_phase_t ph_r, ph_nxt;
	spvp_word_t cfg_r, cfg_nxt;
	logic [15:0] wcnt_r, wcnt_nxt;
	logic [7:0] idx_r, idx_nxt, cnt_r, cnt_nxt;
	logic [6:0] n_r, n_nxt, left_r, left_nxt;
	logic extra_r, extra_nxt, fail_r, fail_nxt;
	logic [2:0] err_r, err_nxt;
	wire spvp_word_t fifo_data_w;
	wire fifo_valid_w;
	wire pop_w = (st_r == H_POP) & fifo_valid_w;
	wire [6:0] n_inc_w = 7'(n_r + 7'd1);
	wire gap_wait_w = wcnt_r == 16'(`SPVP_GAP_CYC - 1);
	wire spvp_word_t expect_w = (ph_r == PH_CFG) ? cfg_r : words[idx_r];

	function automatic logic at_last(input logic [7:0] i, input logic [7:0] n);
		at_last = 8'(i + 8'd1) == n;
	endfunction

	always_comb begin
		st_nxt = st_r;
		ph_nxt = ph_r;
		cur_nxt = cur_r;
		cfg_nxt = cfg_r;
		wcnt_nxt = wcnt_r;
		idx_nxt = idx_r;
		cnt_nxt = cnt_r;
		n_nxt = n_r;
		left_nxt = left_r;
		extra_nxt = extra_r;
		fail_nxt = fail_r;
		err_nxt = err_r;
		unique case (st_r)
			H_IDLE: if (start) begin
				st_nxt = H_EXIT;
				ph_nxt = PH_PROG;
				{idx_nxt, cnt_nxt, cfg_nxt} = {8'h00, n_words, cfg_word};
				{fail_nxt, err_nxt, wcnt_nxt} = '0;
			end
			H_EXIT, H_ENTER: begin
				wcnt_nxt = 16'(wcnt_r + 16'd1);
				if (gap_wait_w) begin
					wcnt_nxt = '0;
					idx_nxt = '0;
					st_nxt = (st_r == H_EXIT) ? H_ENTER :
						(ph_r == PH_PROG) ? H_POP :
						(ph_r == PH_CFG) ? H_CLC : H_VRD;
				end
			end
			H_POP: if (pop_w) begin
				{cur_nxt, n_nxt, extra_nxt} = {fifo_data_w, 7'd0, 1'b0};
				st_nxt = H_PLD;
			end
			H_PLD: if (e_done_w) st_nxt = H_PBG;
			H_PBG: if (e_done_w) st_nxt = H_PWT;
			H_PWT: begin
				wcnt_nxt = 16'(wcnt_r + 16'd1);
				if (wcnt_r == 16'(PROG_CYC - 1)) begin
					wcnt_nxt = '0;
					st_nxt = H_PEN;
				end
			end
			H_PEN: if (e_done_w) begin
				left_nxt = 7'(left_r - 7'd1);
				st_nxt = !extra_r ? H_RD : (left_r != 7'd1) ? H_PLD :
					(ph_r == PH_CFG) ? H_VRD : H_INC;
			end
			H_RD: if (e_done_w) st_nxt = H_CHK;
			H_CHK: begin
				n_nxt = n_inc_w;
				st_nxt = H_PLD;
				if (rx_r == cur_r) begin
					extra_nxt = 1'b1;
					left_nxt = 7'(n_inc_w * `SPVP_EXTRA_MULT);
				end else if (n_inc_w > `SPVP_MAX_TRIES) begin
					fail_nxt = 1'b1;
					st_nxt = H_DONE;
				end
			end
			H_INC: if (e_done_w) begin
				idx_nxt = 8'(idx_r + 8'd1);
				st_nxt = H_POP;
				if (at_last(idx_r, cnt_r)) begin
					ph_nxt = PH_VMIN;
					st_nxt = H_EXIT;
				end
			end
			H_VRD: if (e_done_w) begin
				if (rx_r != expect_w)
					err_nxt[ph_r - PH_VMIN] = 1'b1;
				st_nxt = (ph_r == PH_CFG) ? H_DONE : H_VINC;
			end
			H_VINC: if (e_done_w) begin
				idx_nxt = 8'(idx_r + 8'd1);
				st_nxt = H_VRD;
				if (at_last(idx_r, cnt_r)) begin
					ph_nxt = (ph_r == PH_VMIN) ? PH_VMAX : PH_CFG;
					st_nxt = H_EXIT;
				end
			end
			H_CLC: if (e_done_w) st_nxt = H_CINC;
			H_CINC: if (e_done_w) begin
				idx_nxt = 8'(idx_r + 8'd1);
				if (8'(idx_r + 8'd1) == `SPVP_CFG_WORD_OFS) begin
					{cur_nxt, extra_nxt} = {cfg_r, 1'b1};
					left_nxt = `SPVP_CFG_CYCLES;
					st_nxt = H_PLD;
				end
			end
			H_DONE: st_nxt = H_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			est_r <= E_IDLE;
			st_r <= H_IDLE;
			ph_r <= PH_PROG;
			{ecnt_r, bit_r, sh_r, rx_r, eword_r} <= '0;
			{sclk_r, hoe_r, hdo_r, ehas_r, erd_r} <= '0;
			{cur_r, cfg_r, wcnt_r, idx_r, cnt_r} <= '0;
			{n_r, left_r, extra_r, fail_r, err_r} <= '0;
		end else begin
			est_r <= est_nxt;
			st_r <= st_nxt;
			ph_r <= ph_nxt;
			{ecnt_r, bit_r, sh_r, rx_r, eword_r} <= {ecnt_nxt, bit_nxt,
				sh_nxt, rx_nxt, eword_nxt};
			{sclk_r, hoe_r, hdo_r, ehas_r, erd_r} <= {sclk_nxt, hoe_nxt,
				hdo_nxt, ehas_nxt, erd_nxt};
			{cur_r, cfg_r, wcnt_r, idx_r, cnt_r} <= {cur_nxt, cfg_nxt,
				wcnt_nxt, idx_nxt, cnt_nxt};
			{n_r, left_r, extra_r, fail_r, err_r} <= {n_nxt, left_nxt,
				extra_nxt, fail_nxt, err_nxt};
		end
	end

	// kept for the two verify passes; the fifo has already let go
	always_ff @(posedge clk) begin
		if (pop_w)
			words[idx_r] <= fifo_data_w;
	end

	spvp_fifo #(.W(14), .D(16)) u_fifo (
		.clk(clk),
		.resetn(resetn),
		.in_valid(in_valid),
		.in_ready(in_ready),
		.in_data(in_data),
		.out_valid(fifo_valid_w),
		.out_ready(st_r == H_POP),
		.out_data(fifo_data_w)
	);

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// entry: clock and data idle low before master clear rises
	assign link.master_clear_pin = !(st_r inside {H_IDLE, H_EXIT,
		H_DONE});
	assign link.serial_clock_pin = sclk_r;
	assign link.host_data_o = hdo_r;
	assign link.host_data_oe = hoe_r;
	assign busy = st_r != H_IDLE;
	assign done = st_r == H_DONE;
	assign prog_fail = fail_r;
	assign vmin_err = err_r[0];
	assign vmax_err = err_r[1];
	assign cfg_err = err_r[2];
	assign supply_sel = ph_r;
	assign verify_high_voltage = ph_r inside {PH_VMIN, PH_VMAX};
endmodule // spvp_host

/* spvp_props.sv */
// spvp_props.sv - timing checks on the pins between the two ends
// assumes: the bench instantiates it beside spvp_if, one clock domain
`timescale 1ns/10ps
module spvp_props (
	input wire logic clk,
	input wire logic resetn,
	input wire logic serial_clock_pin,
	input wire logic master_clear_pin,
	input wire logic host_data_o,
	input wire logic host_data_oe,
	input wire logic dev_data_o,
	input wire logic dev_data_oe,
	input wire logic serial_data_pin
);
	// ----------------------------------------
	// helper: length of a device drive window
	// ----------------------------------------
	int rd_cnt_r;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			rd_cnt_r <= 0;
		else
			rd_cnt_r <= dev_data_oe ? rd_cnt_r + 1 : 0;
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence s_hi8;
		serial_clock_pin [*8];
	endsequence
	// rising 2 to rising 16 is 168 clk; slack for the synchroniser
	sequence s_rd_span;
		serial_clock_pin && rd_cnt_r inside {[160:176]};
	endsequence
	AST_NO_CLASH: assert property (!(host_data_oe && dev_data_oe))
		else $error("both ends drive data");
	AST_ENTRY_LOW: assert property ($rose(master_clear_pin) |->
		!serial_clock_pin && !serial_data_pin) else $error("bad entry");
	AST_EXIT_HIZ: assert property ($fell(master_clear_pin) |->
		##[0:8] !dev_data_oe) else $error("drive after exit");
	AST_CLK_HIGH: assert property ($rose(serial_clock_pin) |-> s_hi8)
		else $error("short clock high");
	AST_FALL_STABLE: assert property ($fell(serial_clock_pin) |->
		$stable(serial_data_pin)) else $error("data moves at sample");
	AST_DEV_CHANGE: assert property (dev_data_oe && $changed(dev_data_o)
		|-> serial_clock_pin) else $error("device data off rising");
	AST_HOST_CHANGE: assert property (host_data_oe &&
		$changed(host_data_o) |-> $rose(serial_clock_pin))
		else $error("host data off rising");
	AST_RD_ON: assert property ($rose(dev_data_oe) |->
		serial_clock_pin && !host_data_oe) else $error("bad turnaround");
	AST_RD_LEN: assert property ($fell(dev_data_oe) |-> s_rd_span)
		else $error("bad read window");
endmodule // spvp_props

/* serial_program_verify_port_tb.sv */
// serial_program_verify_port_tb.sv - both ends joined; a zero word, then random ones
// assumes: design files and spvp_props.sv compiled first
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module serial_program_verify_port_tb
	import spvp_pkg::*;
;
	logic clk = 0, resetn = 0, start = 0, in_valid = 0, in_ready, busy, done;
	logic prog_fail, vmin_err, vmax_err, cfg_err, vhv, mode_active;
	logic core_clk_stop, prog_active, mode_q = 0, in_cfg = 0, seen_cfg = 0;
	logic [7:0] n_words = 8'h02;
	logic [5:0] last_cmd;
	logic [63:0] seen_cmd = '0;
	logic [15:0] lfsr_r = 16'h0041;
	spvp_word_t cfg_word = 14'h0000, in_data = 14'h0000;
	spvp_addr_t addr;
	spvp_phase_t supply_sel;
	int err_count = 0, checks_done = 0, k;
	always #5 clk = ~clk;
	spvp_if spvp_if_i ();
	spvp_dev spvp_dev_i (.clk(clk), .resetn(resetn), .link(spvp_if_i.dev),
		.mode_active(mode_active), .core_clk_stop(core_clk_stop),
		.prog_active(prog_active), .addr(addr), .last_cmd(last_cmd));
	// short pulses: the configuration word alone costs 100 cycles
	spvp_host #(.PROG_CYC(10)) spvp_host_i (.clk(clk), .resetn(resetn),
		.link(spvp_if_i.host), .start(start), .n_words(n_words),
		.cfg_word(cfg_word), .in_valid(in_valid), .in_ready(in_ready),
		.in_data(in_data), .busy(busy), .done(done), .prog_fail(prog_fail),
		.vmin_err(vmin_err), .vmax_err(vmax_err), .cfg_err(cfg_err),
		.verify_high_voltage(vhv), .supply_sel(supply_sel));
	spvp_props spvp_props_i (.clk(clk), .resetn(resetn),
		.serial_clock_pin(spvp_if_i.serial_clock_pin),
		.master_clear_pin(spvp_if_i.master_clear_pin),
		.host_data_o(spvp_if_i.host_data_o),
		.host_data_oe(spvp_if_i.host_data_oe),
		.dev_data_o(spvp_if_i.dev_data_o),
		.dev_data_oe(spvp_if_i.dev_data_oe),
		.serial_data_pin(spvp_if_i.serial_data_pin));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic push(input spvp_word_t w);
		in_data = w;
		in_valid = 1;
		for (k = 0; k < 100 && in_ready !== 1'b1; k++)
			@(posedge clk) #1;
		if (k == 100) begin
			err_count++;
			close_out();
		end
		@(posedge clk) #1;
	endtask
	// ----------------------------------------
	// pin-side monitors
	// ----------------------------------------
	always @(posedge clk) begin
		#2;
		if (resetn) begin
			`CHK(core_clk_stop, mode_active)
			if (mode_active && !mode_q) `CHK(addr, 14'h0000)
			if (mode_active && in_cfg) `CHK(addr[13], 1'b1)
			in_cfg = mode_active && (in_cfg || addr[13]);
			if (addr === 14'h2007)
				seen_cfg = 1;
			if (mode_active)
				seen_cmd[last_cmd] = 1;
			mode_q = mode_active;
		end
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge clk);
		#1 resetn = 1;
		@(posedge clk) #1;
		// corner: all-zero word first, then a random one
		push(14'h0000);
		lfsr_r = lfsr(lfsr_r);
		push(lfsr_r[13:0]);
		in_valid = 0;
		lfsr_r = lfsr(lfsr_r);
		cfg_word = lfsr_r[13:0];
		start = 1;
		@(posedge clk) #1;
		start = 0;
		for (k = 0; k < 100000 && done !== 1'b1; k++)
			@(posedge clk) #1;
		if (k == 100000)
			err_count++;
		`CHK(prog_fail, 1'b0)
		`CHK(vmin_err, 1'b0)
		`CHK(vmax_err, 1'b0)
		`CHK(cfg_err, 1'b0)
		`CHK(seen_cfg, 1'b1)
		`CHK(seen_cmd[6'h00], 1'b1)
		`CHK(seen_cmd[6'h02], 1'b1)
		`CHK(seen_cmd[6'h04], 1'b1)
		`CHK(seen_cmd[6'h06], 1'b1)
		`CHK(seen_cmd[6'h08], 1'b1)
		`CHK(seen_cmd[6'h0e], 1'b1)
		close_out();
	end
endmodule // serial_program_verify_port_tb
